// ==== bench/device_id_shift_readout_tb.sv ====
// Testbench joining both ends of the identity readout link
`timescale 1ns/1ps
`default_nettype none

module device_id_shift_readout_tb;
   // Arbitrary identifier for the run
   localparam logic [63:0] ID = 64'hA5C3_1E7F_0B96_D248;
   localparam logic [56:0] IDENT = ID[63:7];
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic user_start = 1'b0;
   logic jtag_start = 1'b0;
   logic jtag_full = 1'b0;
   logic [56:0] user_id;
   logic user_done;
   logic [63:0] jtag_id;
   logic jtag_done;
   logic busy;
   logic halted;
   int fails = 0;
   int checks_done = 0;

   always #25 i_clk = ~i_clk;

   dia_link_if link();

   dia_identity_access_port #(.P_FUSE_ID(ID)) dia_identity_access_port_i (
      .i_clk(i_clk), .i_rstn(i_rstn), .link(link), .o_design_halted(halted));
   dia_identity_host #(.P_DIN_LEVEL(1'b0)) dia_identity_host_i (
      .i_clk(i_clk), .i_rstn(i_rstn), .link(link), .i_user_start(user_start),
      .i_jtag_start(jtag_start), .i_jtag_full(jtag_full), .o_user_id(user_id),
      .o_user_done(user_done), .o_jtag_id(jtag_id), .o_jtag_done(jtag_done), .o_busy(busy));
   dia_link_chk #(.P_FUSE_ID(ID)) dia_link_chk_i (
      .i_clk(i_clk), .i_rstn(i_rstn), .u_read(link.u_read), .u_shift(link.u_shift),
      .u_din(link.u_din), .u_dout(link.u_dout), .tms(link.tms), .tdi(link.tdi),
      .tdo(link.tdo), .o_design_halted(halted));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic step();
      @(posedge i_clk);
      #2;
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_id(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Load then shift out on the wire, msb first, then hold
   task automatic t_user_read();
      int n;
      int k;
      user_start = 1'b1;
      step();
      user_start = 1'b0;
      cmp_bit(busy, 1'b1);
      for (k = 0; k < 57; k++)
      begin
         step();
         cmp_bit(link.u_dout, IDENT[56-k]);
      end
      for (n = 0; n < 10 && user_done !== 1'b1; n++)
         step();
      cmp_bit(user_done, 1'b1);
      cmp_id({7'h00, user_id}, {7'h00, IDENT});
      cmp_bit(busy, 1'b0);
      repeat (4) step();
      cmp_bit(link.u_dout, IDENT[0]);
   endtask

   // Enable, read, disable through JTAG; watch the halt level
   task automatic t_jtag(input logic full);
      int n;
      logic seen;
      logic [63:0] exp;
      exp = full ? ID : {7'h00, IDENT};
      seen = 1'b0;
      jtag_full = full;
      jtag_start = 1'b1;
      step();
      jtag_start = 1'b0;
      cmp_bit(busy, 1'b1);
      for (n = 0; n < 200 && jtag_done !== 1'b1; n++)
      begin
         step();
         if (halted === 1'b1)
            seen = 1'b1;
      end
      cmp_bit(jtag_done, 1'b1);
      cmp_id(jtag_id, exp);
      cmp_bit(seen, 1'b1);
      cmp_bit(busy, 1'b0);
      step();
      step();
      cmp_bit(halted, 1'b0);
   endtask

   // Reset in mid-read, then a clean read
   task automatic t_reset_mid();
      user_start = 1'b1;
      step();
      user_start = 1'b0;
      repeat (10) step();
      i_rstn = 1'b0;
      step();
      cmp_bit(link.u_dout, 1'b0);
      cmp_bit(busy, 1'b0);
      i_rstn = 1'b1;
      step();
      t_user_read();
   endtask

   initial
   begin
      repeat (12) @(posedge i_clk);
      #2;
      i_rstn = 1'b1;
      step();
      t_user_read();
      t_user_read();
      t_jtag(1'b0);
      t_jtag(1'b1);
      t_reset_mid();
      close_out();
   end

   // Several times the expected run length
   initial
   begin
      #(3000 * 50);
      fails++;
      close_out();
   end
endmodule // device_id_shift_readout_tb

`default_nettype wire

// ==== bench/dia_link_chk.sv ====
// Checker of the identity link: user shift port, JTAG path and halt level
`timescale 1ns/1ps
`default_nettype none
`include "dia_cfg.svh"

module dia_link_chk #(
   parameter logic [`DIA_FULL_W-1:0] P_FUSE_ID = 64'h0
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic u_read,
   input wire logic u_shift,
   input wire logic u_din,
   input wire logic u_dout,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic o_design_halted
);
   // ****************************************
   // Shadow state
   // ****************************************
   localparam logic [`DIA_IDENT_W-1:0] IDENT = P_FUSE_ID[`DIA_IDENT_MSB:`DIA_IDENT_LSB];
   // Next TAP state, one nibble per {state, tms}
   localparam logic [127:0] TAP_NEXT = 128'hAEAE_0F31_9B8B_8E31_C576_45C6_D276_3101;
   logic [`DIA_IDENT_W-1:0] sh;
   logic [`DIA_IDENT_W-1:0] next_sh;
   logic [`DIA_IR_W-1:0] ir;
   logic [`DIA_IR_W-1:0] next_ir;
   logic [`DIA_IR_W-1:0] instr;
   logic [`DIA_IR_W-1:0] next_instr;
   logic [3:0] tap;
   logic [3:0] next_tap;

   always_comb
   begin
      next_sh = sh;
      if (u_read)
         next_sh = IDENT;
      else if (u_shift)
         next_sh = {sh[`DIA_IDENT_W-2:0], u_din};
      next_ir = (tap == dia_pkg::DIA_TAP_SH_IR) ? {tdi, ir[`DIA_IR_W-1:1]} : ir;
      next_instr = instr;
      if (tap == dia_pkg::DIA_TAP_RESET)
         next_instr = `DIA_INSTR_BYPASS;
      else if (tap == dia_pkg::DIA_TAP_UPD_IR)
         next_instr = ir;
      next_tap = TAP_NEXT[{3'h0, tap, tms, 2'h0} +: 4];
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         sh <= '0;
         ir <= '0;
         instr <= `DIA_INSTR_BYPASS;
         tap <= dia_pkg::DIA_TAP_RESET;
      end
      else
      begin
         sh <= next_sh;
         ir <= next_ir;
         instr <= next_instr;
         tap <= next_tap;
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_LOAD_MSB: assert property (u_read |=> u_dout == IDENT[`DIA_IDENT_W-1])
      else $error("serial output is not the identity msb after a load");
   AST_READ_WINS: assert property (u_read && u_shift |=> u_dout == IDENT[`DIA_IDENT_W-1])
      else $error("shift was not overridden by a load at the same edge");
   AST_SHIFT_NEXT: assert property (u_read ##1 (u_shift && !u_read) |=> u_dout == IDENT[55])
      else $error("second identity bit missing after one shift");
   AST_DOUT_TRACKS: assert property (u_dout == sh[`DIA_IDENT_W-1])
      else $error("serial output differs from the top bit of the shift register");
   AST_HOLD: assert property (!u_read && !u_shift |=> $stable(u_dout))
      else $error("serial output moved without read or shift");
   AST_DIN_FIXED: assert property (u_shift ##1 u_shift |-> $stable(u_din))
      else $error("serial input changed while shifting");
   AST_COLLECT: assert property (u_read |-> ##56 (u_shift && !u_read) ##1 !u_shift)
      else $error("load not followed by exactly 56 shift cycles");
   AST_ENABLE_FIRST: assert property
      (tap == dia_pkg::DIA_TAP_UPD_IR && ir == `DIA_INSTR_ID_READ |-> o_design_halted)
      else $error("identity read loaded without access enable");
   AST_HALT_ON: assert property
      (tap == dia_pkg::DIA_TAP_UPD_IR && ir == `DIA_INSTR_ENABLE |-> ##[1:2] o_design_halted)
      else $error("design not halted after access enable");
   AST_HALT_OFF: assert property
      (tap == dia_pkg::DIA_TAP_UPD_IR && ir == `DIA_INSTR_DISABLE |-> ##[1:2] !o_design_halted)
      else $error("design still halted after access disable");
   AST_ID_FIRST: assert property (tap == dia_pkg::DIA_TAP_CAP_DR && !tms && o_design_halted
      && instr == `DIA_INSTR_ID_READ |=> tdo == P_FUSE_ID[`DIA_IDENT_MSB])
      else $error("first identity bit on tdo is wrong");
   AST_FULL_FIRST: assert property (tap == dia_pkg::DIA_TAP_CAP_DR && !tms && o_design_halted
      && instr == `DIA_INSTR_FULL_READ |=> tdo == P_FUSE_ID[0])
      else $error("first identifier bit on tdo is wrong");
endmodule // dia_link_chk

`default_nettype wire

// ==== design/dia_cfg.svh ====
// Constants for the device identity readout: widths, instruction codes, TAP figures
`ifndef DIA_CFG_SVH
`define DIA_CFG_SVH

// Identifier widths and the slice that forms the identity value
`define DIA_FULL_W 64
`define DIA_IDENT_W 57
`define DIA_IDENT_MSB 63
`define DIA_IDENT_LSB 7

// Instruction register of the JTAG path (codes are arbitrary)
`define DIA_IR_W 6
`define DIA_IR_CAPTURE 6'h01
`define DIA_INSTR_ENABLE 6'h10
`define DIA_INSTR_DISABLE 6'h16
`define DIA_INSTR_ID_READ 6'h17
`define DIA_INSTR_FULL_READ 6'h32
`define DIA_INSTR_BYPASS 6'h3F

// Host sequencing figures
`define DIA_RST_TMS_ONES 8'h05
`define DIA_RST_LEN 8'h06
`define DIA_IR_HDR 8'h04
`define DIA_DR_HDR 8'h03
`define DIA_TAIL 8'h02
`define DIA_IDENT_LAST 6'h38

`endif

// ==== design/dia_identity_access_port.sv ====
// Device end: identity access port with user shift register and JTAG readout
//
// Function
// - Hold fixed 64-bit identifier, expose 57-bit identity.
// - Identity is identifier bits 63 down to 7.
// - Read high at edge loads all 57 bits.
// - Read beats shift at the same edge.
// - Shift moves toward output, serial input enters bit0.
// - Neither read nor shift: contents and output hold.
// - User may loop output back or insert bits.
// - User holds serial input constant while shifting.
// - Host loads access enable before identity read.
// - Enable halts design; disable afterwards restarts it.
// - Identity bit 56 on TDO entering Shift-DR.
// - Shift-DR shifts remaining bits, then TDI data.
// - Full read shows identifier bit 0 first.
`timescale 1ns/1ps
`default_nettype none
`include "dia_cfg.svh"

module dia_identity_access_port #(
   // Arbitrary identifier value; a real part carries its own fused value
   parameter logic [`DIA_FULL_W-1:0] P_FUSE_ID = 64'h0123_4567_89AB_CDEF
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   dia_link_if.dev link,
   output logic o_design_halted
);

   // ****************************************************************
   // Identity value
   // ****************************************************************
   localparam logic [`DIA_IDENT_W-1:0] IDENT =
      P_FUSE_ID[`DIA_IDENT_MSB:`DIA_IDENT_LSB];

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Next TAP state for a given TMS level
   function automatic dia_pkg::dia_tap_t tap_step(input dia_pkg::dia_tap_t s,
                                                  input logic tms);
      dia_pkg::dia_tap_t n;
      n = s;
      case (s)
         dia_pkg::DIA_TAP_RESET:  n = tms ? dia_pkg::DIA_TAP_RESET  : dia_pkg::DIA_TAP_IDLE;
         dia_pkg::DIA_TAP_IDLE:   n = tms ? dia_pkg::DIA_TAP_SEL_DR : dia_pkg::DIA_TAP_IDLE;
         dia_pkg::DIA_TAP_SEL_DR: n = tms ? dia_pkg::DIA_TAP_SEL_IR : dia_pkg::DIA_TAP_CAP_DR;
         dia_pkg::DIA_TAP_CAP_DR: n = tms ? dia_pkg::DIA_TAP_EX1_DR : dia_pkg::DIA_TAP_SH_DR;
         dia_pkg::DIA_TAP_SH_DR:  n = tms ? dia_pkg::DIA_TAP_EX1_DR : dia_pkg::DIA_TAP_SH_DR;
         dia_pkg::DIA_TAP_EX1_DR: n = tms ? dia_pkg::DIA_TAP_UPD_DR : dia_pkg::DIA_TAP_PA_DR;
         dia_pkg::DIA_TAP_PA_DR:  n = tms ? dia_pkg::DIA_TAP_EX2_DR : dia_pkg::DIA_TAP_PA_DR;
         dia_pkg::DIA_TAP_EX2_DR: n = tms ? dia_pkg::DIA_TAP_UPD_DR : dia_pkg::DIA_TAP_SH_DR;
         dia_pkg::DIA_TAP_UPD_DR: n = tms ? dia_pkg::DIA_TAP_SEL_DR : dia_pkg::DIA_TAP_IDLE;
         dia_pkg::DIA_TAP_SEL_IR: n = tms ? dia_pkg::DIA_TAP_RESET  : dia_pkg::DIA_TAP_CAP_IR;
         dia_pkg::DIA_TAP_CAP_IR: n = tms ? dia_pkg::DIA_TAP_EX1_IR : dia_pkg::DIA_TAP_SH_IR;
         dia_pkg::DIA_TAP_SH_IR:  n = tms ? dia_pkg::DIA_TAP_EX1_IR : dia_pkg::DIA_TAP_SH_IR;
         dia_pkg::DIA_TAP_EX1_IR: n = tms ? dia_pkg::DIA_TAP_UPD_IR : dia_pkg::DIA_TAP_PA_IR;
         dia_pkg::DIA_TAP_PA_IR:  n = tms ? dia_pkg::DIA_TAP_EX2_IR : dia_pkg::DIA_TAP_PA_IR;
         dia_pkg::DIA_TAP_EX2_IR: n = tms ? dia_pkg::DIA_TAP_UPD_IR : dia_pkg::DIA_TAP_SH_IR;
         dia_pkg::DIA_TAP_UPD_IR: n = tms ? dia_pkg::DIA_TAP_SEL_DR : dia_pkg::DIA_TAP_IDLE;
         default:                 n = dia_pkg::DIA_TAP_RESET;
      endcase
      return n;
   endfunction

   // Data register chosen by an instruction; reads need access enabled
   function automatic dia_pkg::dia_dr_sel_t dr_pick(input logic [`DIA_IR_W-1:0] instr,
                                                    input logic enabled);
      dia_pkg::dia_dr_sel_t d;
      d = dia_pkg::DIA_DR_BYPASS;
      if (enabled && (instr == `DIA_INSTR_ID_READ))
      begin
         d = dia_pkg::DIA_DR_IDENT;
      end
      else if (enabled && (instr == `DIA_INSTR_FULL_READ))
      begin
         d = dia_pkg::DIA_DR_FULL;
      end
      return d;
   endfunction

   // ****************************************************************
   // User shift register
   // ****************************************************************
   logic [`DIA_IDENT_W-1:0] ushift;
   logic [`DIA_IDENT_W-1:0] next_ushift;

   always_comb
   begin
      next_ushift = ushift;
      if (link.u_read)
      begin
         next_ushift = IDENT;
      end
      else if (link.u_shift)
      begin
         next_ushift = {ushift[`DIA_IDENT_W-2:0], link.u_din};
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ushift <= '0;
      end
      else
      begin
         ushift <= next_ushift;
      end
   end

   assign link.u_dout = ushift[`DIA_IDENT_W-1];

   // ****************************************************************
   // JTAG TAP, instruction and data registers
   // ****************************************************************
   dia_pkg::dia_tap_t tap;
   dia_pkg::dia_tap_t next_tap;
   logic [`DIA_IR_W-1:0] ir_sh;
   logic [`DIA_IR_W-1:0] next_ir_sh;
   logic [`DIA_IR_W-1:0] ir_act;
   logic [`DIA_IR_W-1:0] next_ir_act;
   logic [`DIA_FULL_W-1:0] dr;
   logic [`DIA_FULL_W-1:0] next_dr;
   logic halted;
   logic next_halted;
   dia_pkg::dia_dr_sel_t dsel;

   assign dsel = dr_pick(ir_act, halted);

   always_comb
   begin
      next_tap = tap_step(tap, link.tms);
      next_ir_sh = ir_sh;
      next_ir_act = ir_act;
      next_dr = dr;
      next_halted = halted;
      case (tap)
         dia_pkg::DIA_TAP_RESET:
         begin
            next_ir_act = `DIA_INSTR_BYPASS;
         end
         dia_pkg::DIA_TAP_CAP_IR:
         begin
            next_ir_sh = `DIA_IR_CAPTURE;
         end
         dia_pkg::DIA_TAP_SH_IR:
         begin
            next_ir_sh = {link.tdi, ir_sh[`DIA_IR_W-1:1]};
         end
         dia_pkg::DIA_TAP_UPD_IR:
         begin
            next_ir_act = ir_sh;
            if (ir_sh == `DIA_INSTR_ENABLE)
            begin
               next_halted = 1'b1;
            end
            else if (ir_sh == `DIA_INSTR_DISABLE)
            begin
               next_halted = 1'b0;
            end
         end
         dia_pkg::DIA_TAP_CAP_DR:
         begin
            next_dr = '0;
            if (dsel == dia_pkg::DIA_DR_IDENT)
            begin
               next_dr[`DIA_IDENT_W-1:0] = IDENT;
            end
            else if (dsel == dia_pkg::DIA_DR_FULL)
            begin
               next_dr = P_FUSE_ID;
            end
         end
         dia_pkg::DIA_TAP_SH_DR:
         begin
            if (dsel == dia_pkg::DIA_DR_IDENT)
            begin
               next_dr[`DIA_IDENT_W-1:0] = {dr[`DIA_IDENT_W-2:0], link.tdi};
            end
            else if (dsel == dia_pkg::DIA_DR_FULL)
            begin
               next_dr = {link.tdi, dr[`DIA_FULL_W-1:1]};
            end
            else
            begin
               next_dr[0] = link.tdi;
            end
         end
         default:
         begin
            next_dr = dr;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         tap <= dia_pkg::DIA_TAP_RESET;
         ir_sh <= `DIA_IR_CAPTURE;
         ir_act <= `DIA_INSTR_BYPASS;
         dr <= '0;
         halted <= 1'b0;
      end
      else
      begin
         tap <= next_tap;
         ir_sh <= next_ir_sh;
         ir_act <= next_ir_act;
         dr <= next_dr;
         halted <= next_halted;
      end
   end

   // ****************************************************************
   // TDO selection
   // ****************************************************************
   always_comb
   begin
      link.tdo = 1'b0;
      if (tap == dia_pkg::DIA_TAP_SH_IR)
      begin
         link.tdo = ir_sh[0];
      end
      else if (tap == dia_pkg::DIA_TAP_SH_DR)
      begin
         if (dsel == dia_pkg::DIA_DR_IDENT)
         begin
            link.tdo = dr[`DIA_IDENT_W-1];
         end
         else
         begin
            link.tdo = dr[0];
         end
      end
   end

   // Halt indication towards the user design
   assign o_design_halted = halted;

endmodule // dia_identity_access_port

`default_nettype wire

// ==== design/dia_identity_host.sv ====
// Far end: user logic reading the access port and a JTAG host sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dia_cfg.svh"

module dia_identity_host #(
   parameter logic P_DIN_LEVEL = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   dia_link_if.host link,
   input wire logic i_user_start,
   input wire logic i_jtag_start,
   input wire logic i_jtag_full,
   output logic [`DIA_IDENT_W-1:0] o_user_id,
   output logic o_user_done,
   output logic [`DIA_FULL_W-1:0] o_jtag_id,
   output logic o_jtag_done,
   output logic o_busy
);

   // ****************************************************************
   // User port reader
   // ****************************************************************
   dia_pkg::dia_ustate_t ust;
   dia_pkg::dia_ustate_t next_ust;
   logic [5:0] ucnt;
   logic [5:0] next_ucnt;
   logic [`DIA_IDENT_W-1:0] next_user_id;
   logic next_user_done;

   assign link.u_read = (ust == dia_pkg::DIA_U_LOAD);
   // Shift is also raised in the load cycle, where the load must win
   assign link.u_shift = (ust == dia_pkg::DIA_U_LOAD) ||
      ((ust == dia_pkg::DIA_U_SHIFT) && (ucnt != `DIA_IDENT_LAST));
   assign link.u_din = P_DIN_LEVEL;

   always_comb
   begin
      next_ust = ust;
      next_ucnt = ucnt;
      next_user_id = o_user_id;
      next_user_done = 1'b0;
      case (ust)
         dia_pkg::DIA_U_IDLE:
         begin
            if (i_user_start)
            begin
               next_ust = dia_pkg::DIA_U_LOAD;
            end
         end
         dia_pkg::DIA_U_LOAD:
         begin
            next_ust = dia_pkg::DIA_U_SHIFT;
            next_ucnt = '0;
         end
         dia_pkg::DIA_U_SHIFT:
         begin
            next_user_id = {o_user_id[`DIA_IDENT_W-2:0], link.u_dout};
            next_ucnt = 6'(ucnt + 6'h01);
            if (ucnt == `DIA_IDENT_LAST)
            begin
               next_ust = dia_pkg::DIA_U_IDLE;
               next_user_done = 1'b1;
            end
         end
         default:
         begin
            next_ust = dia_pkg::DIA_U_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ust <= dia_pkg::DIA_U_IDLE;
         ucnt <= '0;
         o_user_id <= '0;
         o_user_done <= 1'b0;
      end
      else
      begin
         ust <= next_ust;
         ucnt <= next_ucnt;
         o_user_id <= next_user_id;
         o_user_done <= next_user_done;
      end
   end

   // ****************************************************************
   // JTAG sequencer
   // ****************************************************************
   dia_pkg::dia_op_t op;
   dia_pkg::dia_op_t next_op;
   logic [7:0] step;
   logic [7:0] next_step;
   logic full;
   logic next_full;
   logic [`DIA_FULL_W-1:0] next_jtag_id;
   logic next_jtag_done;
   logic [7:0] dr_len;
   logic [7:0] op_len;
   logic [7:0] bidx;
   logic [`DIA_IR_W-1:0] instr;
   logic in_body;

   assign dr_len = full ? 8'(`DIA_FULL_W) : 8'(`DIA_IDENT_W);
   assign bidx = (op == dia_pkg::DIA_OP_DR) ? 8'(step - `DIA_DR_HDR) : 8'(step - `DIA_IR_HDR);

   always_comb
   begin
      instr = `DIA_INSTR_BYPASS;
      op_len = `DIA_RST_LEN;
      in_body = 1'b0;
      link.tms = 1'b0;
      case (op)
         dia_pkg::DIA_OP_RST:
         begin
            link.tms = (step < `DIA_RST_TMS_ONES);
         end
         dia_pkg::DIA_OP_DR:
         begin
            op_len = 8'(`DIA_DR_HDR + dr_len + `DIA_TAIL);
            in_body = (step >= `DIA_DR_HDR) && (bidx < dr_len);
            if (step < `DIA_DR_HDR)
            begin
               link.tms = (step == 8'h00);
            end
            else if (in_body)
            begin
               link.tms = (bidx == 8'(dr_len - 8'h01));
            end
            else
            begin
               link.tms = (bidx == dr_len);
            end
         end
         dia_pkg::DIA_OP_IR_EN, dia_pkg::DIA_OP_IR_RD, dia_pkg::DIA_OP_IR_DIS:
         begin
            if (op == dia_pkg::DIA_OP_IR_EN)
            begin
               instr = `DIA_INSTR_ENABLE;
            end
            else if (op == dia_pkg::DIA_OP_IR_DIS)
            begin
               instr = `DIA_INSTR_DISABLE;
            end
            else
            begin
               instr = full ? `DIA_INSTR_FULL_READ : `DIA_INSTR_ID_READ;
            end
            op_len = 8'(`DIA_IR_HDR + 8'(`DIA_IR_W) + `DIA_TAIL);
            in_body = (step >= `DIA_IR_HDR) && (bidx < 8'(`DIA_IR_W));
            if (step < `DIA_IR_HDR)
            begin
               link.tms = (step < 8'h02);
            end
            else if (in_body)
            begin
               link.tms = (bidx == 8'(`DIA_IR_W - 1));
            end
            else
            begin
               link.tms = (bidx == 8'(`DIA_IR_W));
            end
         end
         default:
         begin
            link.tms = 1'b0;
         end
      endcase
   end

   assign link.tdi = (op != dia_pkg::DIA_OP_DR) && in_body && instr[bidx[2:0]];

   always_comb
   begin
      next_op = op;
      next_step = 8'(step + 8'h01);
      next_full = full;
      next_jtag_id = o_jtag_id;
      next_jtag_done = 1'b0;
      if ((op == dia_pkg::DIA_OP_DR) && in_body)
      begin
         if (full)
         begin
            next_jtag_id = {link.tdo, o_jtag_id[`DIA_FULL_W-1:1]};
         end
         else
         begin
            next_jtag_id = {o_jtag_id[`DIA_FULL_W-2:0], link.tdo};
         end
      end
      if (op == dia_pkg::DIA_OP_IDLE)
      begin
         next_step = '0;
         if (i_jtag_start)
         begin
            next_op = dia_pkg::DIA_OP_RST;
            next_full = i_jtag_full;
            next_jtag_id = '0;
         end
      end
      else if (step == 8'(op_len - 8'h01))
      begin
         next_step = '0;
         case (op)
            dia_pkg::DIA_OP_RST: next_op = dia_pkg::DIA_OP_IR_EN;
            dia_pkg::DIA_OP_IR_EN: next_op = dia_pkg::DIA_OP_IR_RD;
            dia_pkg::DIA_OP_IR_RD: next_op = dia_pkg::DIA_OP_DR;
            dia_pkg::DIA_OP_DR: next_op = dia_pkg::DIA_OP_IR_DIS;
            default:
            begin
               next_op = dia_pkg::DIA_OP_IDLE;
               next_jtag_done = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         op <= dia_pkg::DIA_OP_IDLE;
         step <= '0;
         full <= 1'b0;
         o_jtag_id <= '0;
         o_jtag_done <= 1'b0;
      end
      else
      begin
         op <= next_op;
         step <= next_step;
         full <= next_full;
         o_jtag_id <= next_jtag_id;
         o_jtag_done <= next_jtag_done;
      end
   end

   assign o_busy = (op != dia_pkg::DIA_OP_IDLE) || (ust != dia_pkg::DIA_U_IDLE);

endmodule // dia_identity_host

`default_nettype wire

// ==== design/dia_link_if.sv ====
// Interface joining the identity device and its user logic / JTAG host
`timescale 1ns/1ps
`default_nettype none

interface dia_link_if;
   logic u_read;
   logic u_shift;
   logic u_din;
   logic u_dout;
   logic tms;
   logic tdi;
   logic tdo;

   modport dev (input u_read, input u_shift, input u_din, output u_dout,
                input tms, input tdi, output tdo);
   modport host (output u_read, output u_shift, output u_din, input u_dout,
                 output tms, output tdi, input tdo);
endinterface

`default_nettype wire

// ==== design/dia_pkg.sv ====
// Types shared by both ends of the device identity readout
package dia_pkg;

   // TAP controller states, Gray coded along the usual walk
   typedef enum logic [3:0] {
      DIA_TAP_RESET  = 4'h0,
      DIA_TAP_IDLE   = 4'h1,
      DIA_TAP_SEL_DR = 4'h3,
      DIA_TAP_CAP_DR = 4'h2,
      DIA_TAP_SH_DR  = 4'h6,
      DIA_TAP_EX1_DR = 4'h7,
      DIA_TAP_PA_DR  = 4'h5,
      DIA_TAP_EX2_DR = 4'h4,
      DIA_TAP_UPD_DR = 4'hC,
      DIA_TAP_SEL_IR = 4'hD,
      DIA_TAP_CAP_IR = 4'hF,
      DIA_TAP_SH_IR  = 4'hE,
      DIA_TAP_EX1_IR = 4'hA,
      DIA_TAP_PA_IR  = 4'hB,
      DIA_TAP_EX2_IR = 4'h9,
      DIA_TAP_UPD_IR = 4'h8
   } dia_tap_t;

   // Which data register sits between TDI and TDO
   typedef enum logic [1:0] {
      DIA_DR_BYPASS = 2'h0,
      DIA_DR_IDENT  = 2'h1,
      DIA_DR_FULL   = 2'h3
   } dia_dr_sel_t;

   // Host JTAG sequence steps
   typedef enum logic [2:0] {
      DIA_OP_IDLE   = 3'h0,
      DIA_OP_RST    = 3'h1,
      DIA_OP_IR_EN  = 3'h3,
      DIA_OP_IR_RD  = 3'h2,
      DIA_OP_DR     = 3'h6,
      DIA_OP_IR_DIS = 3'h7
   } dia_op_t;

   // Host user-port read states
   typedef enum logic [1:0] {
      DIA_U_IDLE  = 2'h0,
      DIA_U_LOAD  = 2'h1,
      DIA_U_SHIFT = 2'h3
   } dia_ustate_t;

endpackage
